// ---- logic/anpx_regs.sv ----
`timescale 1ns/10ps
`default_nettype none

module anpx_regs (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire anpx_pkg::anpx_mgmt_req_type mgmt_req,
	output anpx_pkg::anpx_mgmt_rsp_type mgmt_rsp,
	input wire logic base_page_accepted,
	input wire anpx_pkg::anpx_base_page_type base_page_word,
	input wire logic parallel_fault_event,
	input wire logic page_arrived_event,
	input wire logic partner_pages_capable,
	input wire logic partner_negotiation_capable,
	output logic next_pages_done
);

	// ************************************************************
	// state
	// ************************************************************
	anpx_pkg::anpx_base_page_type partner_base_page;
	anpx_pkg::anpx_base_page_type next_partner_base_page;
	logic parallel_detection_fault_latched;
	logic next_parallel_detection_fault_latched;
	logic page_arrived_latched;
	logic next_page_arrived_latched;
	logic pages_capable_q;
	logic next_pages_capable_q;
	logic negotiation_capable_q;
	logic next_negotiation_capable_q;
	anpx_pkg::anpx_mgmt_rsp_type next_mgmt_rsp;
	logic next_next_pages_done;
	logic [15:0] expansion_word;
	logic exp_read;

	// ************************************************************
	// expansion word assembly
	// ************************************************************
	always_comb begin
		expansion_word = 16'h0000;
		expansion_word[anpx_pkg::page_store_location_known_pos] = 1'b1;
		expansion_word[anpx_pkg::page_store_location_pos] = 1'b1;
		expansion_word[anpx_pkg::parallel_detection_fault_latched_pos] = parallel_detection_fault_latched;
		expansion_word[anpx_pkg::partner_pages_capable_pos] = pages_capable_q;
		expansion_word[anpx_pkg::local_pages_capable_pos] = 1'b1;
		expansion_word[anpx_pkg::page_arrived_latched_pos] = page_arrived_latched;
		expansion_word[anpx_pkg::partner_negotiation_capable_pos] = negotiation_capable_q;
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		exp_read = mgmt_req.rd_en && (mgmt_req.addr == anpx_pkg::negotiation_expansion_status_offset);
		next_partner_base_page = partner_base_page;
		if (base_page_accepted) begin
			next_partner_base_page = base_page_word;
		end
		// a read clears the value it returned; a same-cycle event sets again
		next_parallel_detection_fault_latched = parallel_fault_event
			|| (parallel_detection_fault_latched && !exp_read);
		next_page_arrived_latched = page_arrived_event
			|| (page_arrived_latched && !exp_read);
		next_pages_capable_q = partner_pages_capable;
		next_negotiation_capable_q = partner_negotiation_capable;
		// next pages end once the partner sends next-page zero in an accepted base page; the local side is not checked
		next_next_pages_done = next_pages_done;
		if (base_page_accepted) begin
			next_next_pages_done = !base_page_word.partner_more_pages_flag;
		end
		next_mgmt_rsp.rd_valid = mgmt_req.rd_en;
		next_mgmt_rsp.rd_data = 16'h0000;
		if (mgmt_req.rd_en) begin
			case (mgmt_req.addr)
				anpx_pkg::partner_base_page_offset: begin
					next_mgmt_rsp.rd_data = partner_base_page;
				end
				anpx_pkg::negotiation_expansion_status_offset: begin
					next_mgmt_rsp.rd_data = expansion_word;
				end
				default: begin
					next_mgmt_rsp.rd_data = 16'h0000;
				end
			endcase
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			partner_base_page <= anpx_pkg::partner_base_page_reset;
			// flags come out of reset as the expansion word's reset value says
			parallel_detection_fault_latched <= anpx_pkg::negotiation_expansion_status_reset[anpx_pkg::parallel_detection_fault_latched_pos];
			page_arrived_latched <= anpx_pkg::negotiation_expansion_status_reset[anpx_pkg::page_arrived_latched_pos];
			pages_capable_q <= anpx_pkg::negotiation_expansion_status_reset[anpx_pkg::partner_pages_capable_pos];
			negotiation_capable_q <= anpx_pkg::negotiation_expansion_status_reset[anpx_pkg::partner_negotiation_capable_pos];
			mgmt_rsp <= '0;
			next_pages_done <= 1'b0;
		end else begin
			partner_base_page <= next_partner_base_page;
			parallel_detection_fault_latched <= next_parallel_detection_fault_latched;
			page_arrived_latched <= next_page_arrived_latched;
			pages_capable_q <= next_pages_capable_q;
			negotiation_capable_q <= next_negotiation_capable_q;
			mgmt_rsp <= next_mgmt_rsp;
			next_pages_done <= next_next_pages_done;
		end
	end

endmodule

`default_nettype wire

// ---- logic/anpx_pkg.sv ----
package anpx_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [4:0] partner_base_page_offset = 5'h05;
	localparam logic [4:0] negotiation_expansion_status_offset = 5'h06;
	localparam logic [15:0] partner_base_page_reset = 16'h0000;
	localparam logic [15:0] negotiation_expansion_status_reset = 16'h0064;

	// ************************************************************
	// field positions of the partner base page word
	// ************************************************************
	localparam int partner_more_pages_flag_pos = 15;
	localparam int partner_codeword_acknowledged_pos = 14;
	localparam int partner_remote_fault_pos = 13;
	localparam int partner_extended_pages_capable_pos = 12;
	localparam int partner_tech_field_lsb = 5;
	localparam int partner_tech_field_width = 7;
	localparam int partner_message_space_lsb = 0;
	localparam int partner_message_space_width = 5;
	localparam logic [4:0] partner_message_space_ieee = 5'h01;

	// ************************************************************
	// field positions of the expansion status word
	// ************************************************************
	localparam int page_store_location_known_pos = 6;
	localparam int page_store_location_pos = 5;
	localparam int parallel_detection_fault_latched_pos = 4;
	localparam int partner_pages_capable_pos = 3;
	localparam int local_pages_capable_pos = 2;
	localparam int page_arrived_latched_pos = 1;
	localparam int partner_negotiation_capable_pos = 0;

	// partner base page word as fields
	typedef struct packed {
		logic partner_more_pages_flag;
		logic partner_codeword_acknowledged;
		logic partner_remote_fault;
		logic partner_extended_pages_capable;
		logic partner_asym_pause;
		logic partner_sym_pause;
		logic partner_t4_capable;
		logic partner_fast_full_duplex;
		logic partner_fast_half_duplex;
		logic partner_ten_full_duplex;
		logic partner_ten_half_duplex;
		logic [4:0] partner_message_space;
	} anpx_base_page_type;

	// management read request and answer
	typedef struct packed {
		logic rd_en;
		logic [4:0] addr;
	} anpx_mgmt_req_type;

	typedef struct packed {
		logic rd_valid;
		logic [15:0] rd_data;
	} anpx_mgmt_rsp_type;

endpackage

// ---- tb/anpx_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
module anpx_partner (
	input wire logic clk_sys,
	output anpx_pkg::anpx_base_page_type word,
	output logic accepted,
	output logic page_event,
	output logic fault_event,
	output logic pages_able,
	output logic neg_able
);
	initial begin
		word = '0;
		{accepted, page_event, fault_event, pages_able, neg_able} = 5'h00;
	end
	task automatic send(input anpx_pkg::anpx_base_page_type w, input logic fault);
		@(posedge clk_sys) #1;
		word = w;
		accepted = 1'b1;
		page_event = 1'b1;
		fault_event = fault;
		pages_able = w.partner_more_pages_flag;
		neg_able = 1'b1;
		@(posedge clk_sys) #1;
		{accepted, page_event, fault_event} = 3'h0;
		word = ~w;
	endtask
endmodule
`default_nettype wire

// ---- tb/anpx_regs_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module anpx_regs_asserts (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire anpx_pkg::anpx_mgmt_req_type mgmt_req,
	input wire anpx_pkg::anpx_mgmt_rsp_type mgmt_rsp,
	input wire logic base_page_accepted,
	input wire anpx_pkg::anpx_base_page_type base_page_word,
	input wire logic parallel_fault_event,
	input wire logic page_arrived_event,
	input wire logic partner_pages_capable,
	input wire logic partner_negotiation_capable,
	input wire logic next_pages_done
);
	logic [15:0] held, next_held;
	wire logic rd5 = mgmt_req.rd_en && mgmt_req.addr == 5'h05;
	wire logic rd6 = mgmt_req.rd_en && mgmt_req.addr == 5'h06;
	always_comb next_held = base_page_accepted ? base_page_word : held;
	always_ff @(posedge clk_sys) held <= sys_rst ? 16'h0000 : next_held;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence s_fault; parallel_fault_event ##1 !rd6 ##1 rd6; endsequence
	sequence s_page; page_arrived_event ##1 !rd6 ##1 rd6; endsequence
	sequence s_clear; rd6 && !parallel_fault_event ##1 !parallel_fault_event ##1 rd6; endsequence
	a_read_answer: assert property (mgmt_req.rd_en |=> mgmt_rsp.rd_valid)
		else $error("read not answered");
	a_base_word: assert property (rd5 |=> mgmt_rsp.rd_data == $past(held))
		else $error("base page word wrong");
	a_exp_fixed: assert property (rd6 |=> mgmt_rsp.rd_data[15:5] == 11'h003 && mgmt_rsp.rd_data[2])
		else $error("expansion fixed bits wrong");
	a_fault_held: assert property (s_fault |=> mgmt_rsp.rd_data[4])
		else $error("fault flag lost");
	a_page_held: assert property (s_page |=> mgmt_rsp.rd_data[1])
		else $error("page flag lost");
	a_fault_clear: assert property (s_clear |=> !mgmt_rsp.rd_data[4])
		else $error("fault flag not cleared");
	a_caps_shown: assert property (rd6 |=> mgmt_rsp.rd_data[3] == $past(partner_pages_capable, 2) &&
		mgmt_rsp.rd_data[0] == $past(partner_negotiation_capable, 2))
		else $error("partner ability bits wrong");
	a_done_flag: assert property (base_page_accepted |=>
		next_pages_done == !$past(base_page_word.partner_more_pages_flag))
		else $error("next pages done wrong");
endmodule
bind anpx_regs anpx_regs_asserts chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp),
	.base_page_accepted(base_page_accepted), .base_page_word(base_page_word), .parallel_fault_event(parallel_fault_event),
	.page_arrived_event(page_arrived_event), .partner_pages_capable(partner_pages_capable),
	.partner_negotiation_capable(partner_negotiation_capable), .next_pages_done(next_pages_done));
`default_nettype wire

// ---- tb/anpx_regs_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module anpx_regs_tb;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	anpx_pkg::anpx_mgmt_req_type mgmt_req = '0;
	anpx_pkg::anpx_mgmt_rsp_type mgmt_rsp;
	anpx_pkg::anpx_base_page_type word;
	logic acc, pev, fev, local_pages_capable, an_able, done;
	logic [15:0] d;
	int num_errors = 0;
	int n_compared = 0;
	always #4 clk_sys = ~clk_sys;
	anpx_partner partner (.clk_sys(clk_sys), .word(word), .accepted(acc), .page_event(pev), .fault_event(fev),
		.pages_able(local_pages_capable), .neg_able(an_able));
	anpx_regs dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp),
		.base_page_accepted(acc), .base_page_word(word), .parallel_fault_event(fev), .page_arrived_event(pev),
		.partner_pages_capable(local_pages_capable), .partner_negotiation_capable(an_able), .next_pages_done(done));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] q);
		@(posedge clk_sys) #1;
		mgmt_req = '{rd_en: 1'b1, addr: a};
		@(posedge clk_sys) #1;
		mgmt_req.rd_en = 1'b0;
		chk("rd_valid", 16'h0001, {15'h0000, mgmt_rsp.rd_valid});
		q = mgmt_rsp.rd_data;
	endtask
	task automatic t_reset;
		rd(5'h05, d);
		chk("base reset", 16'h0000, d);
		rd(5'h06, d);
		chk("exp reset", 16'h0064, d);
		rd(5'h1f, d);
		chk("unmapped", 16'h0000, d);
		$display("end t_reset");
	endtask
	task automatic t_base;
		fork
			partner.send(16'hd5a1, 1'b0);
			rd(5'h05, d);
		join
		chk("old word", 16'h0000, d);
		rd(5'h05, d);
		chk("base word", 16'hd5a1, d);
		chk("more pages", 16'h0000, {15'h0000, done});
		partner.send(16'h2fe1, 1'b0);
		rd(5'h05, d);
		chk("last word", 16'h2fe1, d);
		chk("pages done", 16'h0001, {15'h0000, done});
		$display("end t_base");
	endtask
	task automatic t_latch;
		rd(5'h06, d);
		chk("exp page", 16'h0067, d);
		rd(5'h06, d);
		chk("exp cleared", 16'h0065, d);
		fork
			partner.send(16'h8001, 1'b1);
			rd(5'h06, d);
		join
		chk("exp coincident", 16'h0065, d);
		rd(5'h06, d);
		chk("exp latched", 16'h007f, d);
		rd(5'h06, d);
		chk("exp read clear", 16'h006d, d);
		$display("end t_latch");
	endtask
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		#1 sys_rst = 1'b0;
		t_reset;
		t_base;
		t_latch;
		finish_test;
	end
	initial begin
		#5000;
		num_errors++;
		finish_test;
	end
endmodule
`default_nettype wire
